// ### rtl/dtm_pkg.sv
// Purpose: Shared constants and types for the diagnostic two-wire target.
// Assumes: Byte-wide maps of 256 entries, host-driven serial clock.
// Notes:   Map offsets are byte indices inside each map.
package dtm_pkg;
    localparam logic [6:0] ID_DEV_ADDR   = 7'h50;
    localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;
    localparam int         MAP_BYTES     = 256;
    localparam int         NUM_MEAS      = 5;
    localparam logic [7:0] USER_BASE     = 8'h80;
    localparam logic [7:0] MEAS_BASE     = 8'h60;
    localparam logic [7:0] MEAS_LAST     = 8'h69;
    localparam logic [7:0] STATUS_OFS    = 8'h6E;
    localparam logic [7:0] ALARM_OFS     = 8'h70;
    localparam logic [7:0] WARN_OFS      = 8'h74;
    localparam logic [7:0] DIAG_TYPE_OFS = 8'h5C;
    localparam int         SIGPRES_BIT   = 1;
    localparam int         CAL_INT_BIT   = 5;
    localparam int         CAL_EXT_BIT   = 4;
    localparam int         THR_STRIDE    = 8;
    localparam int         THR_HI_ALARM  = 0;
    localparam int         THR_LO_ALARM  = 2;
    localparam int         THR_HI_WARN   = 4;
    localparam int         THR_LO_WARN   = 6;

    typedef logic [NUM_MEAS-1:0][15:0] dtm_meas_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WORD, ST_WORD_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
    } dtm_state_e;

    typedef struct packed {
        dtm_state_e               st;
        logic                     scl_s1;
        logic                     scl_s2;
        logic                     scl_d;
        logic                     sda_s1;
        logic                     sda_s2;
        logic                     sda_d;
        logic                     wp_s1;
        logic                     wp_s2;
        logic                     los_s1;
        logic                     los_s2;
        logic [2:0]               cnt;
        logic                     done;
        logic                     rw;
        logic                     map;
        logic [7:0]               ptr;
        logic [7:0]               sh;
        logic                     oe;
        logic                     sigp;
        logic [2*NUM_MEAS-1:0]    alarm;
        logic [2*NUM_MEAS-1:0]    warn;
    } dtm_state_s;
endpackage

// ### rtl/dtm_diag_slave.sv
// Purpose: Two-wire target serving identification and diagnostic maps.
// Assumes: SCL, SDA, WP and loss input are asynchronous; sampled 2FF.
// Notes:   Both bus lines are oversampled by CORE_CLK_IN.
// Contract
// RL1: Answer address 1010000X with a 256-byte nonvolatile identification map.
// RL2: Answer address 1010001X with the separate diagnostic map.
// RL3: Host drives the serial clock; device never drives it.
// RL4: Sample data on clock rise; store only into unprotected segments.
// RL5: Change outgoing data bits on the falling clock edge.
// RL6: Data line is shared; each side drives only during its turn.
// RL7: Host marks start and stop by moving data while clock high.
// RL8: Byte-wide words, single or sequential access with incrementing pointer.
// RL9: Diagnostic byte 110 bit 1 returns inverse of signal-lost state.
// RL10: Set alarm and warning flags when values leave factory limits.
// RL11: Temperature, bias, transmit, receive power and supply readable live.
// RL12: Identification map holds readable capability and maker data.
// RL13: Support internal calibration or raw readings with external constants.
// RL14: Signal-present output high normally, low when input light lost.
// RL15: Writes to protected locations are acked but change nothing.
module dtm_diag_slave #(
    parameter bit CAL_INTERNAL = 1'b1
) (
    input  wire logic              CORE_CLK_IN,     // Core clock, 100 MHz
    input  wire logic              RST_IN,          // Async reset, high
    input  wire logic              SCL_IN,          // Serial clock from host
    input  wire logic              SDA_IN,          // Serial data line level
    output logic                   SDA_OUT,         // Serial data drive value
    output logic                   SDA_OE_OUT,      // High while pulling low
    input  wire logic              WP_IN,           // Write protect, high
    input  wire logic              SIG_LOST_IN,     // Receiver lost light
    input  wire dtm_pkg::dtm_meas_t MEAS_IN,        // Live monitor values
    output logic                   SIG_PRESENT_OUT  // Light detected
);
    dtm_pkg::dtm_state_s r_r;
    dtm_pkg::dtm_state_s r_nxt;
    logic [7:0] id_mem   [dtm_pkg::MAP_BYTES];
    logic [7:0] diag_mem [dtm_pkg::MAP_BYTES];
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic       mem_we;
    logic       addr_hit;
    logic [7:0] rd_byte;
    logic [7:0] status_byte;
    logic [7:0] meas_idx;

    function automatic logic [15:0] thr(input int p, input int o);
        thr = {diag_mem[p*dtm_pkg::THR_STRIDE+o],
               diag_mem[p*dtm_pkg::THR_STRIDE+o+1]};
    endfunction

    // Temperature is two's complement, the rest unsigned
    function automatic logic gt(input logic [15:0] a, input logic [15:0] b,
                                input logic sgn);
        gt = sgn ? ($signed(a) > $signed(b)) : (a > b);
    endfunction

    // Edges seen on second sync stage vs. its delayed copy
    assign scl_rise = r_r.scl_s2 & ~r_r.scl_d;
    assign scl_fall = ~r_r.scl_s2 & r_r.scl_d;
    assign start_c  = r_r.scl_s2 & r_r.scl_d & r_r.sda_d & ~r_r.sda_s2; // RL7
    assign stop_c   = r_r.scl_s2 & r_r.scl_d & ~r_r.sda_d & r_r.sda_s2; // RL7
    assign addr_hit = (r_r.sh[7:1] == dtm_pkg::ID_DEV_ADDR)             // RL1
                   || (r_r.sh[7:1] == dtm_pkg::DIAG_DEV_ADDR);          // RL2
    assign meas_idx = r_r.ptr - dtm_pkg::MEAS_BASE;

    always_comb
    begin
        status_byte = 8'h00;
        status_byte[dtm_pkg::SIGPRES_BIT] = r_r.sigp; // RL9
        rd_byte = diag_mem[r_r.ptr];
        if (!r_r.map)
            rd_byte = id_mem[r_r.ptr]; // RL12
        else if (r_r.ptr >= dtm_pkg::MEAS_BASE
                 && r_r.ptr <= dtm_pkg::MEAS_LAST)
        begin
            // Real-time values, high byte first
            rd_byte = meas_idx[0] ? MEAS_IN[meas_idx[3:1]][7:0]
                                  : MEAS_IN[meas_idx[3:1]][15:8]; // RL11
        end
        else if (r_r.ptr == dtm_pkg::STATUS_OFS)
            rd_byte = status_byte; // RL9
        else if (r_r.ptr == dtm_pkg::ALARM_OFS)
            rd_byte = r_r.alarm[9:2]; // RL10
        else if (r_r.ptr == dtm_pkg::ALARM_OFS + 8'h01)
            rd_byte = {r_r.alarm[1:0], 6'h00};
        else if (r_r.ptr == dtm_pkg::WARN_OFS)
            rd_byte = r_r.warn[9:2]; // RL10
        else if (r_r.ptr == dtm_pkg::WARN_OFS + 8'h01)
            rd_byte = {r_r.warn[1:0], 6'h00};
        else if (r_r.ptr == dtm_pkg::DIAG_TYPE_OFS)
        begin
            rd_byte = 8'h00;
            rd_byte[dtm_pkg::CAL_INT_BIT] = CAL_INTERNAL;  // RL13
            rd_byte[dtm_pkg::CAL_EXT_BIT] = !CAL_INTERNAL; // RL13
        end
    end

    always_comb
    begin
        r_nxt = r_r;
        mem_we = 1'b0;
        r_nxt.scl_s1 = SCL_IN; // RL3
        r_nxt.scl_s2 = r_r.scl_s1;
        r_nxt.scl_d  = r_r.scl_s2;
        r_nxt.sda_s1 = SDA_IN;
        r_nxt.sda_s2 = r_r.sda_s1;
        r_nxt.sda_d  = r_r.sda_s2;
        r_nxt.wp_s1  = WP_IN;
        r_nxt.wp_s2  = r_r.wp_s1;
        r_nxt.los_s1 = SIG_LOST_IN;
        r_nxt.los_s2 = r_r.los_s1;
        r_nxt.sigp   = !r_r.los_s2; // RL14
        for (int p = 0; p < dtm_pkg::NUM_MEAS; p++)
        begin
            r_nxt.alarm[9-2*p] = gt(MEAS_IN[p],
                thr(p, dtm_pkg::THR_HI_ALARM), p == 0); // RL10
            r_nxt.alarm[8-2*p] = gt(thr(p, dtm_pkg::THR_LO_ALARM),
                MEAS_IN[p], p == 0); // RL10
            r_nxt.warn[9-2*p]  = gt(MEAS_IN[p],
                thr(p, dtm_pkg::THR_HI_WARN), p == 0); // RL10
            r_nxt.warn[8-2*p]  = gt(thr(p, dtm_pkg::THR_LO_WARN),
                MEAS_IN[p], p == 0); // RL10
        end
        if (start_c)
        begin
            r_nxt.st   = dtm_pkg::ST_ADDR;
            r_nxt.cnt  = 3'h0;
            r_nxt.done = 1'b0;
            r_nxt.oe   = 1'b0;
        end
        else if (stop_c)
        begin
            r_nxt.st = dtm_pkg::ST_IDLE;
            r_nxt.oe = 1'b0; // RL6
        end
        else if (scl_rise)
        begin
            unique case (r_r.st)
                dtm_pkg::ST_ADDR, dtm_pkg::ST_WORD, dtm_pkg::ST_WDATA:
                begin
                    r_nxt.sh   = {r_r.sh[6:0], r_r.sda_s2}; // RL4
                    r_nxt.cnt  = r_r.cnt + 3'h1;
                    r_nxt.done = (r_r.cnt == 3'h7);
                end
                dtm_pkg::ST_RDATA:
                begin
                    r_nxt.cnt  = r_r.cnt + 3'h1;
                    r_nxt.done = (r_r.cnt == 3'h7);
                end
                dtm_pkg::ST_RACK:
                begin
                    // Host not acknowledging ends the sequential read
                    if (r_r.sda_s2)
                        r_nxt.st = dtm_pkg::ST_IDLE;
                end
                dtm_pkg::ST_IDLE, dtm_pkg::ST_ADDR_ACK,
                dtm_pkg::ST_WORD_ACK, dtm_pkg::ST_WDATA_ACK: ;
            endcase
        end
        else if (scl_fall)
        begin
            unique case (r_r.st)
                dtm_pkg::ST_ADDR:
                begin
                    if (r_r.done)
                    begin
                        r_nxt.done = 1'b0;
                        r_nxt.st   = dtm_pkg::ST_IDLE;
                        if (addr_hit)
                        begin
                            r_nxt.oe  = 1'b1; // RL5
                            r_nxt.map = r_r.sh[1]; // RL2
                            r_nxt.rw  = r_r.sh[0];
                            r_nxt.st  = dtm_pkg::ST_ADDR_ACK;
                        end
                    end
                end
                dtm_pkg::ST_WORD:
                begin
                    if (r_r.done)
                    begin
                        r_nxt.done = 1'b0;
                        r_nxt.ptr  = r_r.sh; // RL8
                        r_nxt.oe   = 1'b1;
                        r_nxt.st   = dtm_pkg::ST_WORD_ACK;
                    end
                end
                dtm_pkg::ST_WDATA:
                begin
                    if (r_r.done)
                    begin
                        r_nxt.done = 1'b0;
                        // Protected bytes still acked, store skipped
                        mem_we = !r_r.wp_s2
                              || r_r.ptr >= dtm_pkg::USER_BASE; // RL15
                        r_nxt.ptr = r_r.ptr + 8'h01; // RL8
                        r_nxt.oe  = 1'b1;
                        r_nxt.st  = dtm_pkg::ST_WDATA_ACK;
                    end
                end
                dtm_pkg::ST_WORD_ACK, dtm_pkg::ST_WDATA_ACK:
                begin
                    r_nxt.oe = 1'b0; // RL6
                    r_nxt.st = dtm_pkg::ST_WDATA;
                end
                dtm_pkg::ST_ADDR_ACK, dtm_pkg::ST_RACK:
                begin
                    r_nxt.cnt = 3'h0;
                    r_nxt.oe  = 1'b0;
                    r_nxt.st  = dtm_pkg::ST_WORD;
                    if (r_r.rw || r_r.st == dtm_pkg::ST_RACK)
                    begin
                        r_nxt.sh = rd_byte;
                        r_nxt.oe = !rd_byte[7]; // RL5
                        r_nxt.st = dtm_pkg::ST_RDATA;
                    end
                end
                dtm_pkg::ST_RDATA:
                begin
                    if (r_r.done)
                    begin
                        r_nxt.done = 1'b0;
                        r_nxt.oe   = 1'b0; // RL6
                        r_nxt.ptr  = r_r.ptr + 8'h01; // RL8
                        r_nxt.st   = dtm_pkg::ST_RACK;
                    end
                    else
                    begin
                        r_nxt.oe = !r_r.sh[~r_r.cnt]; // RL5
                    end
                end
                dtm_pkg::ST_IDLE: ;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
            r_r <= '0;
        else
            r_r <= r_nxt;
    end

    // Array kept out of reset: it models nonvolatile storage
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (mem_we)
        begin
            if (r_r.map)
                diag_mem[r_r.ptr] <= r_r.sh; // RL4
            else
                id_mem[r_r.ptr] <= r_r.sh; // RL1
        end
    end

    assign SDA_OUT         = 1'b0;
    assign SDA_OE_OUT      = r_r.oe;
    assign SIG_PRESENT_OUT = r_r.sigp;

    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);

    // Three flops from pin to output, so the drop is due on the third edge
    sig_present_a: assert property ($rose(SIG_LOST_IN) |-> // RL14
        ##3 !SIG_PRESENT_OUT)
        else $error("signal present not dropped after loss");
    status_bit_a: assert property ( // RL9
        r_r.map && r_r.ptr == dtm_pkg::STATUS_OFS
        |-> rd_byte[dtm_pkg::SIGPRES_BIT] == !$past(r_r.los_s2))
        else $error("status bit does not follow signal lost");
    addr_nack_a: assert property (scl_fall // RL1
        && r_r.st == dtm_pkg::ST_ADDR && r_r.done && !addr_hit
        |=> !r_r.oe ##0 r_r.st == dtm_pkg::ST_IDLE)
        else $error("foreign address was acknowledged");
    addr_ack_a: assert property (scl_fall // RL2
        && r_r.st == dtm_pkg::ST_ADDR && r_r.done && addr_hit
        |=> r_r.oe && r_r.map == $past(r_r.sh[1]))
        else $error("own address not acknowledged");
    write_protect_a: assert property (scl_fall // RL15
        && r_r.st == dtm_pkg::ST_WDATA && r_r.done && r_r.wp_s2
        && r_r.ptr < dtm_pkg::USER_BASE |-> !mem_we)
        else $error("write into protected segment");
    read_incr_a: assert property (scl_fall // RL8
        && r_r.st == dtm_pkg::ST_RDATA && r_r.done
        |=> r_r.ptr == $past(r_r.ptr) + 8'h01)
        else $error("read pointer did not advance");
    oe_on_fall_a: assert property ($changed(r_r.oe) |-> // RL5
        $past(scl_fall || start_c || stop_c))
        else $error("data drive changed away from falling edge");
    stop_release_a: assert property (stop_c |=> !SDA_OE_OUT[*2]) // RL6
        else $error("data line held after stop");
    alarm_hi_a: assert property ($signed(MEAS_IN[0]) > // RL10
        $signed({diag_mem[0], diag_mem[1]}) |=> r_r.alarm[9])
        else $error("temperature high alarm not set");
    live_read_a: assert property (scl_fall // RL11
        && r_r.st == dtm_pkg::ST_ADDR_ACK && r_r.rw && r_r.map
        && r_r.ptr == dtm_pkg::MEAS_BASE
        |=> r_r.sh == $past(MEAS_IN[0][15:8]))
        else $error("live temperature byte not loaded");

    read_start_c: cover property (r_r.st == dtm_pkg::ST_ADDR_ACK && r_r.rw
        ##[1:300] r_r.st == dtm_pkg::ST_RDATA);
    write_store_c: cover property (mem_we && r_r.map);
    seq_read_c: cover property (r_r.st == dtm_pkg::ST_RACK
        ##[1:300] r_r.st == dtm_pkg::ST_RDATA);
endmodule

// ### testbench/dtm_host_model.sv
// Purpose: Host controller model for the two-wire management bus.
// Assumes: Data wire is open drain with a pull-up resolved by the bench.
// Notes:   One bit takes 16 core cycles, so 160 ns per serial clock.
module dtm_host_model (
    input  wire logic CLK_IN,   // Core clock used for pacing
    input  wire logic SDA_IN,   // Resolved data wire level
    output logic      SCL_OUT,  // Serial clock, idles high
    output logic      PULL_OUT  // High while pulling data low
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        SCL_OUT = 1'b1;
        PULL_OUT = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_IN);
    endtask
    // Also serves as repeated start from a low clock
    task automatic start_c();
        PULL_OUT <= 1'b0;
        tick(4);
        SCL_OUT <= 1'b1;
        tick(8);
        PULL_OUT <= 1'b1;
        tick(8);
        SCL_OUT <= 1'b0;
        tick(4);
    endtask
    task automatic stop_c();
        PULL_OUT <= 1'b1;
        tick(4);
        SCL_OUT <= 1'b1;
        tick(8);
        PULL_OUT <= 1'b0;
        tick(8);
    endtask
    // Data only moves while the clock is low
    task automatic bit_c(input logic b, output logic s);
        PULL_OUT <= !b;
        tick(4);
        SCL_OUT <= 1'b1;
        tick(4);
        s = SDA_IN;
        tick(4);
        SCL_OUT <= 1'b0;
        tick(4);
    endtask
    task automatic byte_w(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_c(d[i], s);
        bit_c(1'b1, s);
        ack = !s;
    endtask
    task automatic byte_r(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_c(1'b1, s);
            d[i] = s;
        end
        bit_c(last, s);
    endtask
endmodule

// ### testbench/tb_top.sv
// Purpose: Self-checking bench for the diagnostic two-wire target.
// Assumes: Memories start unknown, so every byte read is written first.
// Notes:   Thresholds use one pattern for all five monitored values.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 60000;
    logic               core_clk;
    logic               rst;
    logic               wp;
    logic               lost;
    dtm_pkg::dtm_meas_t meas;
    logic               scl;
    logic               pull;
    logic               sda_out;
    logic               sda_oe;
    logic               sigp;
    logic               sda_w;
    logic [7:0]         wq [0:39];
    logic [7:0]         rq [0:9];
    int                 error_cnt;
    int                 samples_checked;
    int                 cyc;
    // Pull-up wins unless someone pulls low
    assign sda_w = !(pull | (sda_oe & !sda_out));
    dtm_diag_slave dut_u (.CORE_CLK_IN(core_clk), .RST_IN(rst),
        .SCL_IN(scl), .SDA_IN(sda_w), .SDA_OUT(sda_out),
        .SDA_OE_OUT(sda_oe), .WP_IN(wp), .SIG_LOST_IN(lost),
        .MEAS_IN(meas), .SIG_PRESENT_OUT(sigp));
    dtm_host_model host_u (.CLK_IN(core_clk), .SDA_IN(sda_w),
        .SCL_OUT(scl), .PULL_OUT(pull));
    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
                      input int n, output logic ok);
        logic a;
        host_u.start_c();
        host_u.byte_w({dev, 1'b0}, ok);
        if (ok)
        begin
            host_u.byte_w(ptr, a);
            ok = ok & a;
            for (int i = 0; i < n; i++)
            begin
                host_u.byte_w(wq[i], a);
                ok = ok & a;
            end
        end
        host_u.stop_c();
    endtask
    task automatic rd(input logic [6:0] dev, input logic [7:0] ptr,
                      input int n);
        logic a;
        host_u.start_c();
        host_u.byte_w({dev, 1'b0}, a);
        host_u.byte_w(ptr, a);
        host_u.start_c();
        host_u.byte_w({dev, 1'b1}, a);
        for (int i = 0; i < n; i++)
            host_u.byte_r(i == n - 1, rq[i]);
        host_u.stop_c();
    endtask
    task automatic t_idmap();
        logic ok;
        wq[0] = 8'hA5;
        wq[1] = 8'h5A;
        wr(dtm_pkg::ID_DEV_ADDR, 8'hFF, 2, ok);
        chk("id_ack", ok, 1'b1);
        rd(dtm_pkg::ID_DEV_ADDR, 8'hFF, 2);
        chk("id_ff", rq[0], 8'hA5);
        chk("id_wrap", rq[1], 8'h5A);
        rd(dtm_pkg::ID_DEV_ADDR, 8'h00, 1);
        chk("id_single", rq[0], 8'h5A);
    endtask
    task automatic t_protect();
        logic ok;
        wp <= 1'b1;
        wq[0] = 8'hC3;
        wr(dtm_pkg::ID_DEV_ADDR, 8'h00, 1, ok);
        chk("wp_ack", ok, 1'b1);
        rd(dtm_pkg::ID_DEV_ADDR, 8'h00, 1);
        chk("wp_kept", rq[0], 8'h5A);
        wr(dtm_pkg::ID_DEV_ADDR, 8'hFF, 1, ok);
        rd(dtm_pkg::ID_DEV_ADDR, 8'hFF, 1);
        chk("wp_upper", rq[0], 8'hC3);
        wp <= 1'b0;
        wr(7'h52, 8'h00, 1, ok);
        chk("bad_addr", ok, 1'b0);
    endtask
    task automatic t_sigpres();
        lost <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk("sigp_lost", sigp, 1'b0);
        rd(dtm_pkg::DIAG_DEV_ADDR, dtm_pkg::STATUS_OFS, 1);
        chk("stat_lost", rq[0], 8'h00);
        lost <= 1'b0;
        repeat (5) @(posedge core_clk);
        chk("sigp_ok", sigp, 1'b1);
        rd(dtm_pkg::DIAG_DEV_ADDR, dtm_pkg::STATUS_OFS, 1);
        chk("stat_ok", rq[0], 8'h02);
    endtask
    task automatic t_alarm();
        logic ok;
        for (int i = 0; i < 40; i++)
            wq[i] = (i % 8 == 0) ? 8'h40 : (i % 8 == 2) ? 8'h10 :
                    (i % 8 == 4) ? 8'h30 : (i % 8 == 6) ? 8'h20 : 8'h00;
        wr(dtm_pkg::DIAG_DEV_ADDR, 8'h00, 40, ok);
        meas <= {16'h1800, 16'h3800, 16'h0800, 16'h2800, 16'h5000};
        repeat (4) @(posedge core_clk);
        rd(dtm_pkg::DIAG_DEV_ADDR, dtm_pkg::MEAS_BASE, 10);
        for (int p = 0; p < 5; p++)
            chk("live", {rq[2*p], rq[2*p+1]}, meas[p]);
        rd(dtm_pkg::DIAG_DEV_ADDR, dtm_pkg::ALARM_OFS, 2);
        chk("alarm", {rq[0], rq[1]}, 16'h8400);
        rd(dtm_pkg::DIAG_DEV_ADDR, dtm_pkg::WARN_OFS, 2);
        chk("warn", {rq[0], rq[1]}, 16'h8640);
        rd(dtm_pkg::DIAG_DEV_ADDR, dtm_pkg::DIAG_TYPE_OFS, 1);
        chk("cal", rq[0] & 8'h30, 8'h20);
        rd(dtm_pkg::ID_DEV_ADDR, 8'h00, 1);
        chk("maps_apart", rq[0], 8'h5A);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Hang guard, far above the expected run length
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            error_cnt++;
            wrap_up();
        end
    end
    initial
    begin
        rst = 1'b1;
        wp = 1'b0;
        lost = 1'b0;
        meas = '0;
        cyc = 0;
        error_cnt = 0;
        samples_checked = 0;
        repeat (4) @(posedge core_clk);
        chk("sigp_rst", sigp, 1'b0);
        chk("oe_rst", sda_oe, 1'b0);
        chk("sda_val", sda_out, 1'b0);
        rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        t_idmap();
        t_protect();
        t_sigpres();
        t_alarm();
        wrap_up();
    end
endmodule
